// ### logic/spf_map.svh
/*
 Constants of the slot power enable and fault logic: timing, register
 offsets, field positions and reset values.
 Assumes a 25 MHz system clock and 32-bit register words.
*/
`ifndef SPF_MAP_SVH
`define SPF_MAP_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define SPF_CLK_NS       40
`define SPF_MIN_LOW_NS   200
`define SPF_INT_FILT_NS  10000

// ----------------------------------------
// Controller registers
// ----------------------------------------
`define SPF_REG_CTRL     8'h00
`define SPF_REG_STAT     8'h04
`define SPF_REG_ISR      8'h08
`define SPF_REG_IMR      8'h0c
`define SPF_REG_PULSE    8'h10
`define SPF_POS_MAIN     0
`define SPF_POS_AUX      8
`define SPF_POS_PG       16
`define SPF_CTRL_RST     32'h0000_0000
`define SPF_IMR_RST      32'h0000_0000

`endif

// ### logic/spf_pkg.sv
/*
 Shared types of the slot power enable and fault logic.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package spf_pkg;
	typedef logic [1:0]  spf_resp_t;
	typedef logic [31:0] spf_word_t;
	localparam spf_resp_t SPF_OKAY   = 2'h0;
	localparam spf_resp_t SPF_SLVERR = 2'h2;
endpackage

// ### logic/spf_link_if.sv
/*
 Pins between the slot power device and its hot-plug controller.
 Enables carry an internal pull-up; fault and power-good lines are
 open-drain with an external pull-up; this interface resolves them.
*/
interface spf_link_if #(parameter int N = 2);
	logic [N-1:0] main_en_out;
	logic [N-1:0] main_en_oe;
	logic [N-1:0] aux_en_out;
	logic [N-1:0] aux_en_oe;
	logic [N-1:0] main_en;
	logic [N-1:0] aux_en;
	logic [N-1:0] flt_main_oe;
	logic [N-1:0] flt_aux_oe;
	logic [N-1:0] pg_oe;
	logic [N-1:0] flt_main_n;
	logic [N-1:0] flt_aux_n;
	logic [N-1:0] slot_power_good_n;

	// Undriven enable reads high, undriven open-drain line reads high
	assign main_en           = (main_en_out | ~main_en_oe);
	assign aux_en            = (aux_en_out | ~aux_en_oe);
	assign flt_main_n        = ~flt_main_oe;
	assign flt_aux_n         = ~flt_aux_oe;
	assign slot_power_good_n = ~pg_oe;

	modport dev (input main_en, aux_en, output flt_main_oe, flt_aux_oe, pg_oe);
	modport ctl (output main_en_out, main_en_oe, aux_en_out, aux_en_oe,
		input flt_main_n, flt_aux_n, slot_power_good_n);
endinterface

// ### logic/spf_device.sv
/*
 Device end: per-slot breaker timing, fault latches, gate enables and
 power-good qualification for N slots.
 Assumes analog monitors arrive as asynchronous levels and the
 controller drives the enables through the link interface.
*/
`include "spf_map.svh"

module spf_device #(
	parameter int N           = 2,
	parameter int INT_FILT_NS = `SPF_INT_FILT_NS
) (
	input  wire logic         i_sys_clk,
	input  wire logic         i_reset_n,
	spf_link_if.dev           lnk,
	input  wire logic [N-1:0] i_limit_active,
	input  wire logic [N-1:0] i_limit_filter_cap_pin_gnd,
	input  wire logic [N-1:0] i_ext_filter_done,
	input  wire logic [N-1:0] i_thermal_fault,
	input  wire logic [N-1:0] i_input_uv,
	input  wire logic [N-1:0] i_standby_supply_uvlo,
	input  wire logic [N-1:0] i_aux_overcurrent,
	input  wire logic [N-1:0] i_overtemp,
	input  wire logic [N-1:0] i_high_rail_good,
	input  wire logic [N-1:0] i_low_rail_good,
	input  wire logic [N-1:0] i_standby_rail_good,
	output logic      [N-1:0] o_high_rail_gate_on,
	output logic      [N-1:0] o_low_rail_gate_drive,
	output logic      [N-1:0] o_standby_rail_output,
	output logic      [N-1:0] o_limit_regulate,
	output logic      [N-1:0] o_main_breaker_tripped,
	output logic      [N-1:0] o_aux_breaker_tripped
);

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	function automatic int ns_to_cycles(input int ns);
		return (ns + `SPF_CLK_NS - 1) / `SPF_CLK_NS;
	endfunction

	// Filter is a hold time, so round up; pulse width is a least time
	localparam int LIM_CYC = ns_to_cycles(INT_FILT_NS);
	localparam int LOW_CYC = ns_to_cycles(`SPF_MIN_LOW_NS);
	localparam int LW      = $clog2(LIM_CYC + 1);
	localparam int PW      = $clog2(LOW_CYC + 1);
	localparam int W       = 13 * N;

	// ----------------------------------------
	// Input synchroniser
	// ----------------------------------------
	logic [W-1:0] raw;
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] stb_q;
	logic [N-1:0] lim;
	logic [N-1:0] capg;
	logic [N-1:0] extd;
	logic [N-1:0] therm;
	logic [N-1:0] uv;
	logic [N-1:0] sbuv;
	logic [N-1:0] aoc;
	logic [N-1:0] otmp;
	logic [N-1:0] hg;
	logic [N-1:0] lg;
	logic [N-1:0] sg;
	logic [N-1:0] men;
	logic [N-1:0] aen;

	assign raw = {i_limit_active, i_limit_filter_cap_pin_gnd, i_ext_filter_done,
		i_thermal_fault, i_input_uv, i_standby_supply_uvlo, i_aux_overcurrent,
		i_overtemp, i_high_rail_good, i_low_rail_good, i_standby_rail_good,
		lnk.main_en, lnk.aux_en};

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// A bit changes only once the last two stages agree
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			stb_q <= '0;
		end else begin
			stb_q <= (stb_q & (s2_q ^ s3_q)) | (s3_q & ~(s2_q ^ s3_q));
		end
	end

	assign {lim, capg, extd, therm, uv, sbuv, aoc, otmp, hg, lg, sg, men, aen} = stb_q;

	// ----------------------------------------
	// Per-slot logic
	// ----------------------------------------
	for (genvar s = 0; s < N; s++) begin : g_slot
		logic [LW-1:0] lim_cnt_q;
		logic [PW-1:0] mlow_q;
		logic [PW-1:0] alow_q;
		logic          trip;
		logic          atrip;
		logic          mclr;
		logic          aclr;
		logic          mflt_q;
		logic          aflt_q;
		logic          mbrk_q;
		logic          abrk_q;

		// Unless the filter cap pin is grounded, the shorter of the two filters ends the limit interval
		assign trip  = men[s] & lim[s] & ~mbrk_q
			& ((lim_cnt_q == LW'(LIM_CYC - 1))
			| (~capg[s] & extd[s]));
		assign atrip = aen[s] & aoc[s];

		// A clear fires once the low level has lasted the least width
		assign mclr  = ~men[s] & (mlow_q == PW'(LOW_CYC - 1));
		assign aclr  = ~aen[s] & (alow_q == PW'(LOW_CYC - 1));

		always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
			if (!i_reset_n) begin
				lim_cnt_q <= '0;
			end else if (men[s] & lim[s] & ~mbrk_q & ~trip) begin
				lim_cnt_q <= lim_cnt_q + 1'b1;
			end else begin
				lim_cnt_q <= '0;
			end
		end

		always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
			if (!i_reset_n) begin
				mlow_q <= '0;
				alow_q <= '0;
			end else begin
				if (men[s]) begin
					mlow_q <= '0;
				end else if (mlow_q != PW'(LOW_CYC)) begin
					mlow_q <= mlow_q + 1'b1;
				end
				if (aen[s]) begin
					alow_q <= '0;
				end else if (alow_q != PW'(LOW_CYC)) begin
					alow_q <= alow_q + 1'b1;
				end
			end
		end

		// Latches are separate, so each needs its own enable pulse
		always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
			if (!i_reset_n) begin
				mflt_q <= 1'b0;
				aflt_q <= 1'b0;
			end else begin
				mflt_q <= trip | uv[s] | (mflt_q & ~mclr);
				aflt_q <= atrip | otmp[s] | (aflt_q & ~aclr);
			end
		end

		// Breakers hold until the fault line has been released
		always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
			if (!i_reset_n) begin
				mbrk_q <= 1'b0;
				abrk_q <= 1'b0;
			end else begin
				mbrk_q <= trip | (mbrk_q & mflt_q);
				abrk_q <= atrip | (abrk_q & aflt_q);
			end
		end

		// Gates fall in the same cycle as the fault, not one later
		assign o_low_rail_gate_drive[s] = men[s] & ~mbrk_q & ~trip
			& ~therm[s] & ~uv[s];
		assign o_high_rail_gate_on[s]   = men[s] & ~mbrk_q & ~trip
			& ~therm[s] & ~uv[s];
		assign o_limit_regulate[s]      = men[s] & lim[s] & ~mbrk_q & ~trip;
		assign o_standby_rail_output[s] = aen[s] & ~sbuv[s] & ~abrk_q
			& ~atrip & ~otmp[s];
		assign o_main_breaker_tripped[s] = mbrk_q;
		assign o_aux_breaker_tripped[s]  = abrk_q;

		assign lnk.flt_main_oe[s] = mflt_q;
		assign lnk.flt_aux_oe[s]  = aflt_q;
		assign lnk.pg_oe[s]       = men[s] & aen[s] & hg[s] & lg[s] & sg[s]
			& ~mflt_q & ~aflt_q & ~mbrk_q & ~abrk_q
			& ~therm[s] & ~uv[s] & ~sbuv[s];
	end

endmodule

// ### logic/spf_ctrl.sv
/*
 Controller end: drives the slot enables and reads fault and power-good
 lines; software reaches it over an AXI4-Lite slave.
 Assumes the link interface resolves the open-drain lines.
*/
`include "spf_map.svh"

module spf_ctrl #(
	parameter int N = 2
) (
	input  wire logic        i_sys_clk,
	input  wire logic        i_reset_n,
	spf_link_if.ctl          lnk,
	input  wire logic [7:0]  i_s_axi_awaddr,
	input  wire logic        i_s_axi_awvalid,
	output logic             o_s_axi_awready,
	input  wire logic [31:0] i_s_axi_wdata,
	input  wire logic [3:0]  i_s_axi_wstrb,
	input  wire logic        i_s_axi_wvalid,
	output logic             o_s_axi_wready,
	output spf_pkg::spf_resp_t o_s_axi_bresp,
	output logic             o_s_axi_bvalid,
	input  wire logic        i_s_axi_bready,
	input  wire logic [7:0]  i_s_axi_araddr,
	input  wire logic        i_s_axi_arvalid,
	output logic             o_s_axi_arready,
	output spf_pkg::spf_word_t o_s_axi_rdata,
	output spf_pkg::spf_resp_t o_s_axi_rresp,
	output logic             o_s_axi_rvalid,
	input  wire logic        i_s_axi_rready,
	output logic             o_irq
);

	localparam int LOW_CYC = (`SPF_MIN_LOW_NS + `SPF_CLK_NS - 1) / `SPF_CLK_NS;

	function automatic logic known(input logic [7:0] a);
		return a == `SPF_REG_CTRL || a == `SPF_REG_STAT || a == `SPF_REG_ISR
			|| a == `SPF_REG_IMR || a == `SPF_REG_PULSE;
	endfunction

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	spf_pkg::spf_word_t ctrl_q;
	spf_pkg::spf_word_t isr_q;
	spf_pkg::spf_word_t imr_q;
	spf_pkg::spf_word_t stat;
	spf_pkg::spf_word_t ev;
	spf_pkg::spf_word_t prev_q;
	spf_pkg::spf_word_t mask;
	logic [7:0]         awa_q;
	logic               awh_q;
	logic               wh_q;
	spf_pkg::spf_word_t wd_q;
	logic [3:0]         ws_q;
	logic               wr;
	logic [3:0]         hold_q [2*N];

	assign mask = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};
	assign wr   = awh_q & wh_q & ~o_s_axi_bvalid;

	always_comb begin
		stat = '0;
		stat[`SPF_POS_MAIN +: N] = ~lnk.flt_main_n;
		stat[`SPF_POS_AUX +: N]  = ~lnk.flt_aux_n;
		stat[`SPF_POS_PG +: N]   = ~lnk.slot_power_good_n;
	end

	// Fault assertions and any power-good change raise events
	assign ev = (stat & ~prev_q & {16'h0000, 16'hffff}) | ((stat ^ prev_q) & {16'hffff, 16'h0000});

	// ----------------------------------------
	// Write channel
	// ----------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			awh_q <= 1'b0;
			awa_q <= '0;
			wh_q  <= 1'b0;
			wd_q  <= '0;
			ws_q  <= '0;
		end else begin
			if (i_s_axi_awvalid && o_s_axi_awready) begin
				awh_q <= 1'b1;
				awa_q <= i_s_axi_awaddr;
			end else if (wr) begin
				awh_q <= 1'b0;
			end
			if (i_s_axi_wvalid && o_s_axi_wready) begin
				wh_q <= 1'b1;
				wd_q <= i_s_axi_wdata;
				ws_q <= i_s_axi_wstrb;
			end else if (wr) begin
				wh_q <= 1'b0;
			end
		end
	end

	assign o_s_axi_awready = ~awh_q & ~o_s_axi_bvalid;
	assign o_s_axi_wready  = ~wh_q & ~o_s_axi_bvalid;

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_s_axi_bvalid <= 1'b0;
			o_s_axi_bresp  <= spf_pkg::SPF_OKAY;
		end else if (wr) begin
			o_s_axi_bvalid <= 1'b1;
			o_s_axi_bresp  <= known(awa_q) ? spf_pkg::SPF_OKAY : spf_pkg::SPF_SLVERR;
		end else if (i_s_axi_bready) begin
			o_s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ctrl_q <= `SPF_CTRL_RST;
			imr_q  <= `SPF_IMR_RST;
		end else if (wr && awa_q == `SPF_REG_CTRL) begin
			ctrl_q <= (ctrl_q & ~mask) | (wd_q & mask);
		end else if (wr && awa_q == `SPF_REG_IMR) begin
			imr_q <= (imr_q & ~mask) | (wd_q & mask);
		end
	end

	// New events win over a write-one clear in the same cycle
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			isr_q  <= '0;
			prev_q <= '0;
		end else begin
			prev_q <= stat;
			isr_q  <= (isr_q & ~((wr && awa_q == `SPF_REG_ISR) ? (wd_q & mask) : '0)) | ev;
		end
	end

	assign o_irq = |(isr_q & imr_q);

	// ----------------------------------------
	// Enable drive
	// ----------------------------------------
	// A pulse request forces the enable low for the least width;
	// index s is the main enable, N+s the standby enable of slot s
	for (genvar e = 0; e < 2*N; e++) begin : g_hold
		localparam int B = (e < N) ? (`SPF_POS_MAIN + e) : (`SPF_POS_AUX + e - N);
		always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
			if (!i_reset_n) begin
				hold_q[e] <= '0;
			end else if (wr && awa_q == `SPF_REG_PULSE && wd_q[B] && mask[B]) begin
				hold_q[e] <= 4'(LOW_CYC);
			end else if (hold_q[e] != 4'h0) begin
				hold_q[e] <= hold_q[e] - 4'h1;
			end
		end
	end

	for (genvar s = 0; s < N; s++) begin : g_en
		assign lnk.main_en_out[s] = ctrl_q[`SPF_POS_MAIN + s] & (hold_q[s] == 4'h0);
		assign lnk.aux_en_out[s]  = ctrl_q[`SPF_POS_AUX + s] & (hold_q[N+s] == 4'h0);
	end

	assign lnk.main_en_oe = '1;
	assign lnk.aux_en_oe  = '1;

	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	assign o_s_axi_arready = ~o_s_axi_rvalid;

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_s_axi_rvalid <= 1'b0;
			o_s_axi_rdata  <= '0;
			o_s_axi_rresp  <= spf_pkg::SPF_OKAY;
		end else if (i_s_axi_arvalid && o_s_axi_arready) begin
			o_s_axi_rvalid <= 1'b1;
			o_s_axi_rresp  <= known(i_s_axi_araddr) ? spf_pkg::SPF_OKAY : spf_pkg::SPF_SLVERR;
			unique case (i_s_axi_araddr)
				`SPF_REG_CTRL: o_s_axi_rdata <= ctrl_q;
				`SPF_REG_STAT: o_s_axi_rdata <= stat;
				`SPF_REG_ISR:  o_s_axi_rdata <= isr_q;
				`SPF_REG_IMR:  o_s_axi_rdata <= imr_q;
				default:       o_s_axi_rdata <= '0;
			endcase
		end else if (i_s_axi_rready) begin
			o_s_axi_rvalid <= 1'b0;
		end
	end

endmodule

// ### sim/spf_link_assertions.sv
/*
 Checker on slot 0 of the link between the slot power device and its controller,
 plus the slot 0 device pins that give the link signals their cause.
 Assumes one clock domain and the bench instantiating it beside the link.
*/
module spf_link_assertions #(
	parameter int N    = 2,
	parameter int FILT = 10
) (
	input wire logic         i_sys_clk,
	input wire logic         i_reset_n,
	input wire logic [N-1:0] main_en,
	input wire logic [N-1:0] aux_en,
	input wire logic [N-1:0] flt_main_n,
	input wire logic [N-1:0] flt_aux_n,
	input wire logic [N-1:0] slot_power_good_n,
	input wire logic [N-1:0] i_input_uv,
	input wire logic [N-1:0] i_thermal_fault,
	input wire logic [N-1:0] i_standby_supply_uvlo,
	input wire logic [N-1:0] i_overtemp,
	input wire logic [N-1:0] o_high_rail_gate_on,
	input wire logic [N-1:0] o_low_rail_gate_drive,
	input wire logic [N-1:0] o_standby_rail_output,
	input wire logic [N-1:0] o_limit_regulate,
	input wire logic [N-1:0] o_main_breaker_tripped,
	input wire logic [N-1:0] o_aux_breaker_tripped
);
	// ----------------------------------------
	// Helper counters
	// ----------------------------------------
	// Two cycles of slack cover the synchroniser and the trip flop
	localparam int LIM = FILT + 2;

	logic [1:0]      en_w;
	logic [1:0]      flt_w;
	logic [1:0][2:0] run_q;
	logic [1:0]      seen_q;
	logic [7:0]      reg_cnt_q;

	assign en_w  = {aux_en[0], main_en[0]};
	assign flt_w = {flt_aux_n[0], flt_main_n[0]};

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			reg_cnt_q <= 8'h00;
		end else begin
			reg_cnt_q <= o_limit_regulate[0] ? reg_cnt_q + 8'h01 : 8'h00;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			run_q <= '0;
		end else begin
			for (int j = 0; j < 2; j++) begin
				if (en_w[j]) begin
					run_q[j] <= 3'h0;
				end else if (run_q[j] != 3'h7) begin
					run_q[j] <= run_q[j] + 3'h1;
				end
			end
		end
	end

	// A long low pulse is remembered until the next fault, so a release needs a fresh one
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			seen_q <= 2'h0;
		end else begin
			seen_q <= (seen_q | {run_q[1] >= 3'h5, run_q[0] >= 3'h5}) & ~(~flt_w & $past(flt_w));
		end
	end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);

	a_limit_bounded: assert property (reg_cnt_q <= LIM)
		else $error("regulation outlasted the filter time");
	a_trip_sets_fault: assert property ($rose(o_main_breaker_tripped[0]) |=> !flt_main_n[0])
		else $error("trip did not assert the main fault line");
	a_uv_sets_fault: assert property ((i_input_uv[0]) [*8] |-> !flt_main_n[0])
		else $error("undervoltage did not assert the main fault line");
	a_temp_sets_aux: assert property ((i_overtemp[0]) [*8] |-> !flt_aux_n[0])
		else $error("overtemperature did not assert the aux fault line");
	a_trip_gates_off: assert property (o_main_breaker_tripped[0] |-> !o_low_rail_gate_drive[0] && !o_high_rail_gate_on[0])
		else $error("gate on with breaker tripped");
	a_heat_gate_off: assert property ((i_thermal_fault[0]) [*8] |-> !o_low_rail_gate_drive[0])
		else $error("gate on during thermal fault");
	a_lockout_aux_off: assert property ((i_standby_supply_uvlo[0]) [*8] |-> !o_standby_rail_output[0])
		else $error("standby output on during lockout");
	a_main_en_off: assert property ((!main_en[0]) [*8] |-> !o_high_rail_gate_on[0] && !o_low_rail_gate_drive[0])
		else $error("main gates on with enable low");
	a_aux_en_off: assert property ((!aux_en[0]) [*8] |-> !o_standby_rail_output[0])
		else $error("standby output on with enable low");
	a_main_clear_width: assert property ($rose(flt_main_n[0]) |-> seen_q[0])
		else $error("main fault released without a long enough low pulse");
	a_aux_clear_width: assert property ($rose(flt_aux_n[0]) |-> seen_q[1])
		else $error("aux fault released without a long enough low pulse");
	a_main_rearm_order: assert property ($fell(o_main_breaker_tripped[0]) |-> $past(flt_main_n[0]) && flt_main_n[0])
		else $error("main breaker re-armed before the fault release");
	a_aux_rearm_order: assert property ($fell(o_aux_breaker_tripped[0]) |-> $past(flt_aux_n[0]) && flt_aux_n[0])
		else $error("aux breaker re-armed before the fault release");
	a_pg_no_fault: assert property (!slot_power_good_n[0] |-> flt_main_n[0] && flt_aux_n[0])
		else $error("power good asserted during a fault");
	a_pg_needs_en: assert property ((!main_en[0] || !aux_en[0]) [*8] |-> slot_power_good_n[0])
		else $error("power good asserted with an enable low");
endmodule

// ### sim/slot_power_enable_fault_logic_test.sv
/*
 Bench for the slot power device and its controller joined by the link.
 Assumes two slots and an internal filter shortened to 10 cycles.
*/
`include "spf_map.svh"

module slot_power_enable_fault_logic_test;
	timeunit 1ns;
	timeprecision 1ns;

	logic               clk, rst_n, irq;
	logic               awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
	logic [7:0]         awaddr, araddr;
	logic [31:0]        wdata, rd;
	logic [3:0]         wstrb;
	spf_pkg::spf_word_t rdata;
	spf_pkg::spf_resp_t bresp, rresp, rsp;
	logic [1:0]         lim, cap, ext, therm, uv, uvlo, aoc, otmp, hgd, lgd, sgd;
	logic [1:0]         hgate, lgate, sout, reg_on, mtrip, atrip;
	int                 miscompares, samples_checked;

	spf_link_if #(.N(2)) spf_link_if_inst ();
	wire [1:0] fm_n = spf_link_if_inst.flt_main_n;
	wire [1:0] fa_n = spf_link_if_inst.flt_aux_n;
	wire [1:0] pg_n = spf_link_if_inst.slot_power_good_n;

	spf_device #(.N(2), .INT_FILT_NS(400)) spf_device_inst (.i_sys_clk(clk), .i_reset_n(rst_n),
		.lnk(spf_link_if_inst.dev), .i_limit_active(lim), .i_limit_filter_cap_pin_gnd(cap), .i_ext_filter_done(ext),
		.i_thermal_fault(therm), .i_input_uv(uv), .i_standby_supply_uvlo(uvlo), .i_aux_overcurrent(aoc),
		.i_overtemp(otmp), .i_high_rail_good(hgd), .i_low_rail_good(lgd), .i_standby_rail_good(sgd),
		.o_high_rail_gate_on(hgate), .o_low_rail_gate_drive(lgate), .o_standby_rail_output(sout),
		.o_limit_regulate(reg_on), .o_main_breaker_tripped(mtrip), .o_aux_breaker_tripped(atrip));
	spf_ctrl #(.N(2)) spf_ctrl_inst (.i_sys_clk(clk), .i_reset_n(rst_n), .lnk(spf_link_if_inst.ctl),
		.i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
		.i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
		.o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
		.o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
		.i_s_axi_rready(rready), .o_irq(irq));
	spf_link_assertions #(.N(2), .FILT(10)) spf_link_assertions_inst (.i_sys_clk(clk), .i_reset_n(rst_n),
		.main_en(spf_link_if_inst.main_en), .aux_en(spf_link_if_inst.aux_en), .flt_main_n(fm_n), .flt_aux_n(fa_n),
		.slot_power_good_n(pg_n), .i_input_uv(uv), .i_thermal_fault(therm), .i_standby_supply_uvlo(uvlo),
		.i_overtemp(otmp), .o_high_rail_gate_on(hgate), .o_low_rail_gate_drive(lgate),
		.o_standby_rail_output(sout), .o_limit_regulate(reg_on), .o_main_breaker_tripped(mtrip),
		.o_aux_breaker_tripped(atrip));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t ns: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Address and data are offered together and each released once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
		int k;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (k = 0; k < 50 && !bvalid; k++) begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end
		bready <= 1'b0;
		rsp = bresp;
		if (k == 50) miscompares++;
		if (k == 50) results();
	endtask

	task automatic rdr(input logic [7:0] a);
		int k;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (k = 0; k < 50 && !rvalid; k++) begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end
		rready <= 1'b0;
		rd = rdata;
		rsp = rresp;
		if (k == 50) miscompares++;
		if (k == 50) results();
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs();
		rdr(`SPF_REG_CTRL);
		check(rd, `SPF_CTRL_RST);
		rdr(`SPF_REG_PULSE);
		check(rd, 32'h0000_0000);
		rdr(8'h14);
		check(32'(rsp), 32'(spf_pkg::SPF_SLVERR));
		wr(8'h14, 32'h0000_0001);
		check(32'(rsp), 32'(spf_pkg::SPF_SLVERR));
		wr(`SPF_REG_CTRL, 32'hffff_ffff, 4'h2);
		rdr(`SPF_REG_CTRL);
		check(rd, 32'h0000_ff00);
		wr(`SPF_REG_CTRL, 32'h0000_0000);
		rdr(`SPF_REG_CTRL);
		check(rd, 32'h0000_0000);
		$display("registers done");
	endtask

	task automatic t_power();
		wr(`SPF_REG_CTRL, 32'h0000_0101);
		idle(12);
		check(32'({hgate, lgate, sout, pg_n}), 32'h56);
		rdr(`SPF_REG_STAT);
		check(rd, 32'h0001_0000);
		check(32'(irq), 32'h0);
		wr(`SPF_REG_IMR, 32'h0001_0101);
		wr(`SPF_REG_ISR, 32'h0001_0000);
		lgd <= 2'b10;
		idle(8);
		check(32'({irq, pg_n}), 32'h7);
		lgd <= 2'b11;
		hgd <= 2'b10;
		idle(8);
		check(32'(pg_n), 32'h3);
		hgd <= 2'b11;
		sgd <= 2'b10;
		idle(8);
		check(32'(pg_n), 32'h3);
		sgd <= 2'b11;
		idle(8);
		wr(`SPF_REG_ISR, 32'hffff_ffff);
		check(32'({irq, pg_n}), 32'h2);
		$display("power up done");
	endtask

	// Slot 0 has a grounded filter pin, so its external filter input must be ignored
	task automatic t_trip();
		cap <= 2'b01;
		ext <= 2'b01;
		lim <= 2'b01;
		idle(6);
		check(32'({reg_on, mtrip}), 32'h4);
		idle(14);
		check(32'({irq, mtrip, lgate, hgate, fm_n, pg_n}), 32'h50b);
		lim <= 2'b00;
		ext <= 2'b00;
		idle(6);
		wr(`SPF_REG_PULSE, 32'h0000_0001);
		idle(20);
		check(32'({mtrip, lgate, fm_n, pg_n}), 32'h1e);
		wr(`SPF_REG_CTRL, 32'h0000_0303);
		idle(12);
		lim <= 2'b10;
		ext <= 2'b10;
		idle(8);
		check(32'(mtrip), 32'h2);
		lim <= 2'b00;
		ext <= 2'b00;
		idle(6);
		wr(`SPF_REG_PULSE, 32'h0000_0002);
		idle(20);
		check(32'({mtrip, fm_n}), 32'h3);
		wr(`SPF_REG_ISR, 32'hffff_ffff);
		$display("breaker trip done");
	endtask

	task automatic t_both();
		uv <= 2'b01;
		therm <= 2'b01;
		otmp <= 2'b01;
		idle(10);
		check(32'({fm_n, fa_n, lgate}), 32'h2a);
		uv <= 2'b00;
		therm <= 2'b00;
		otmp <= 2'b00;
		idle(6);
		wr(`SPF_REG_PULSE, 32'h0000_0001);
		idle(20);
		check(32'({fm_n, fa_n}), 32'he);
		wr(`SPF_REG_PULSE, 32'h0000_0100);
		idle(20);
		check(32'(fa_n), 32'h3);
		aoc <= 2'b10;
		idle(10);
		check(32'({atrip, fa_n, sout}), 32'h25);
		aoc <= 2'b00;
		idle(6);
		wr(`SPF_REG_PULSE, 32'h0000_0200);
		idle(20);
		check(32'({atrip, fa_n}), 32'h3);
		wr(`SPF_REG_ISR, 32'hffff_ffff);
		$display("double fault done");
	endtask

	task automatic t_stby();
		uvlo <= 2'b01;
		idle(10);
		check(32'(sout), 32'h2);
		uvlo <= 2'b00;
		idle(10);
		check(32'(sout), 32'h3);
		wr(`SPF_REG_CTRL, 32'h0000_0003);
		idle(10);
		check(32'({hgate, sout, pg_n}), 32'h33);
		$display("standby done");
	endtask

	// ----------------------------------------
	// Clock and main sequence
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	initial begin
		rst_n = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hf;
		{lim, cap, ext, therm, uv, uvlo, aoc, otmp} = '0;
		{hgd, lgd, sgd} = 6'h3f;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_power();
		t_trip();
		t_both();
		t_stby();
		results();
	end
endmodule
